// ---- verilog/hbr_top.sv ----
// Receive clock-enable generator, paced receive output and 8-bit host management bus.
`timescale 1ns/10ps
`default_nettype none
module hbr_top (
	input  wire logic                         clk_i,
	input  wire logic                         sys_rst_i,
	input  wire hbr_pkg::hbr_rate_t           rate_i,
	output logic                              out_ce_source_o,
	input  wire logic                         out_ce_sink_i,
	input  wire logic                         rx_valid_i,
	output logic                              rx_ready_o,
	input  wire logic [hbr_pkg::DATA_W-1:0]   rx_data_i,
	input  wire logic                         rx_dv_i,
	input  wire logic                         rx_er_i,
	output logic      [hbr_pkg::DATA_W-1:0]   gmii_rxd_o,
	output logic                              gmii_rx_dv_o,
	output logic                              gmii_rx_er_o,
	input  wire logic                         host_cs_n_i,
	input  wire logic                         host_write_n_i,
	input  wire logic [hbr_pkg::ADDR_W-1:0]   host_addr_i,
	input  wire logic [hbr_pkg::DATA_W-1:0]   host_wdata_i,
	output logic      [hbr_pkg::DATA_W-1:0]   host_rdata_o,
	output logic                              host_ready_n_o
);
	import hbr_pkg::*;

	localparam int REGS = 1 << ADDR_W;

	// Clock-enable divider.
	logic [CNT_W-1:0] ce_cnt_reg;
	logic [CNT_W-1:0] ce_cnt_next;
	logic [CNT_W-1:0] ce_div;
	logic             ce_reg;
	logic             ce_next;

	always_comb begin
		case (rate_i)
			HBR_RATE_1G:   ce_div = CNT_W'(DIV_1G);
			HBR_RATE_100M: ce_div = CNT_W'(DIV_100M);
			HBR_RATE_10M:  ce_div = CNT_W'(DIV_10M);
			default:       ce_div = CNT_W'(DIV_1G);
		endcase
		// A rate change that leaves the count past the new period restarts it.
		if (ce_cnt_reg + CNT_ONE >= ce_div) begin
			ce_cnt_next = CNT_ZERO;
		end else begin
			ce_cnt_next = ce_cnt_reg + CNT_ONE;
		end
		ce_next = (ce_cnt_next == CNT_ZERO);
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ce_cnt_reg <= CNT_ZERO;
			ce_reg     <= 1'b0;
		end else begin
			ce_cnt_reg <= ce_cnt_next;
			ce_reg     <= ce_next;
		end
	end

	assign out_ce_source_o = ce_reg;

	// Receive path: buffer, then launch on the enable sink.
	logic              buf_valid;
	logic [WORD_W-1:0] buf_data;
	logic [WORD_W-1:0] out_word_reg;
	logic [WORD_W-1:0] out_word_next;

	hbr_buf2 #(
		.WIDTH(WORD_W)
	) u_buf (
		.clk_i      (clk_i),
		.sys_rst_i  (sys_rst_i),
		.in_valid_i (rx_valid_i),
		.in_ready_o (rx_ready_o),
		.in_data_i  ({rx_er_i, rx_dv_i, rx_data_i}),
		.out_valid_o(buf_valid),
		.out_ready_i(out_ce_sink_i),
		.out_data_o (buf_data)
	);

	always_comb begin
		out_word_next = out_word_reg;
		// An enabled edge with nothing buffered launches an idle word.
		if (out_ce_sink_i) begin
			out_word_next = buf_valid ? buf_data : '0;
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			out_word_reg <= '0;
		end else begin
			out_word_reg <= out_word_next;
		end
	end

	assign gmii_rxd_o   = out_word_reg[DATA_W-1:0];
	assign gmii_rx_dv_o = out_word_reg[BIT_DV];
	assign gmii_rx_er_o = out_word_reg[BIT_ER];

	// Host management bus and its register store.
	logic [DATA_W-1:0] regs_mem [REGS];
	hbr_host_state_t   host_st_reg;
	hbr_host_state_t   host_st_next;
	logic [DATA_W-1:0] rdata_reg;
	logic [DATA_W-1:0] rdata_next;
	logic              ready_n_reg;
	logic              ready_n_next;
	logic              wr_en;

	always_comb begin
		host_st_next = host_st_reg;
		rdata_next   = rdata_reg;
		ready_n_next = ready_n_reg;
		wr_en        = 1'b0;
		case (host_st_reg)
			HBR_HOST_IDLE: begin
				if (!host_cs_n_i) begin
					if (!host_write_n_i) begin
						wr_en = 1'b1;
					end else begin
						rdata_next = regs_mem[host_addr_i];
					end
					ready_n_next = 1'b0;
					host_st_next = HBR_HOST_DONE;
				end
			end
			HBR_HOST_DONE: begin
				// Ready is held until chip select is released.
				if (host_cs_n_i) begin
					ready_n_next = 1'b1;
					host_st_next = HBR_HOST_IDLE;
				end
			end
			default: begin
				ready_n_next = 1'b1;
				host_st_next = HBR_HOST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			host_st_reg <= HBR_HOST_IDLE;
			rdata_reg   <= REG_RST;
			ready_n_reg <= 1'b1;
		end else begin
			host_st_reg <= host_st_next;
			rdata_reg   <= rdata_next;
			ready_n_reg <= ready_n_next;
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			for (int i = 0; i < REGS; i++) begin
				regs_mem[i] <= REG_RST;
			end
		end else if (wr_en) begin
			regs_mem[host_addr_i] <= host_wdata_i;
		end
	end

	assign host_rdata_o   = rdata_reg;
	assign host_ready_n_o = ready_n_reg;
endmodule : hbr_top
`default_nettype wire

// ---- verilog/hbr_pkg.sv ----
// Constants shared by the receive clock-enable and host bus block.
// Operation
// - Receive data and control outputs are launched from the single reference clock.
// - The block drives a receive clock-enable source output paced by the rate.
// - Enable is always high at 1 Gbps, 1-in-10 at 100 Mbps, 1-in-100 at 10 Mbps.
// - A new receive word is launched only on edges where the enable sink is high.
// - Host bus transfers are sampled and driven on the block clock.
// - Host gives 6-bit address and 8-bit write data; block returns 8-bit read data.
// - On a write, ready goes low only after the data is stored.
// - On a read, ready goes low only once valid data sits on the read bus.
package hbr_pkg;
	localparam int CLK_MHZ  = 250;
	localparam int ADDR_W   = 6;
	localparam int DATA_W   = 8;
	localparam int WORD_W   = DATA_W + 2;
	localparam int CNT_W    = 7;
	localparam int DIV_1G   = 1;
	localparam int DIV_100M = 10;
	localparam int DIV_10M  = 100;
	localparam logic [CNT_W-1:0] CNT_ZERO = 7'h00;
	localparam logic [CNT_W-1:0] CNT_ONE  = 7'h01;
	localparam logic [DATA_W-1:0] REG_RST = 8'h00;
	localparam int BIT_DV = DATA_W;
	localparam int BIT_ER = DATA_W + 1;

	typedef enum logic [1:0] {
		HBR_RATE_10M  = 2'b00,
		HBR_RATE_100M = 2'b01,
		HBR_RATE_1G   = 2'b10
	} hbr_rate_t;

	typedef enum logic [0:0] {
		HBR_HOST_IDLE = 1'b0,
		HBR_HOST_DONE = 1'b1
	} hbr_host_state_t;
endpackage : hbr_pkg

// ---- verilog/hbr_buf2.sv ----
// Two-entry valid/ready buffer in the receive data path.
`timescale 1ns/10ps
`default_nettype none
module hbr_buf2 #(
	parameter int WIDTH = 10
) (
	input  wire logic             clk_i,
	input  wire logic             sys_rst_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [WIDTH-1:0] out_data_o
);
	logic [WIDTH-1:0] mem_reg [2];
	logic [WIDTH-1:0] mem_next [2];
	logic             rd_ptr_reg;
	logic             rd_ptr_next;
	logic             wr_ptr_reg;
	logic             wr_ptr_next;
	logic [1:0]       count_reg;
	logic [1:0]       count_next;
	logic             push;
	logic             pop;

	assign in_ready_o  = (count_reg != 2'h2);
	assign out_valid_o = (count_reg != 2'h0);
	assign out_data_o  = mem_reg[rd_ptr_reg];
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;

	always_comb begin
		mem_next[0] = mem_reg[0];
		mem_next[1] = mem_reg[1];
		if (push) begin
			mem_next[wr_ptr_reg] = in_data_i;
		end
		wr_ptr_next = push ? ~wr_ptr_reg : wr_ptr_reg;
		rd_ptr_next = pop ? ~rd_ptr_reg : rd_ptr_reg;
		count_next  = count_reg;
		if (push && !pop) begin
			count_next = count_reg + 2'h1;
		end else if (pop && !push) begin
			count_next = count_reg - 2'h1;
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			mem_reg[0] <= '0;
			mem_reg[1] <= '0;
			rd_ptr_reg <= 1'b0;
			wr_ptr_reg <= 1'b0;
			count_reg  <= 2'h0;
		end else begin
			mem_reg[0] <= mem_next[0];
			mem_reg[1] <= mem_next[1];
			rd_ptr_reg <= rd_ptr_next;
			wr_ptr_reg <= wr_ptr_next;
			count_reg  <= count_next;
		end
	end
endmodule : hbr_buf2
`default_nettype wire

// ---- verification/hbr_props.sv ----
// Checker for enable pacing, receive hold and host handshake.
`timescale 1ns/10ps
`default_nettype none
module hbr_props (
	input wire logic                       clk_i,
	input wire logic                       sys_rst_i,
	input wire hbr_pkg::hbr_rate_t         rate_i,
	input wire logic                       out_ce_source_o,
	input wire logic                       out_ce_sink_i,
	input wire logic [hbr_pkg::DATA_W-1:0] gmii_rxd_o,
	input wire logic                       host_cs_n_i,
	input wire logic                       host_ready_n_o
);
	import hbr_pkg::*;
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	property p_ce_1g;
		rate_i == HBR_RATE_1G && out_ce_source_o ##1 rate_i == HBR_RATE_1G |-> out_ce_source_o;
	endproperty
	a_ce_1g: assert property (p_ce_1g) else $error("ce low at 1G");
	property p_ce_100m;
		rate_i == HBR_RATE_100M && $stable(rate_i) && $past(out_ce_source_o, 10)
			&& $past(rate_i, 10) == HBR_RATE_100M |-> out_ce_source_o;
	endproperty
	a_ce_100m: assert property (p_ce_100m) else $error("ce period 100M");
	property p_ce_10m;
		rate_i == HBR_RATE_10M && $stable(rate_i) && $past(out_ce_source_o, 100)
			&& $past(rate_i, 100) == HBR_RATE_10M |-> out_ce_source_o;
	endproperty
	a_ce_10m: assert property (p_ce_10m) else $error("ce period 10M");
	property p_ce_gap;
		out_ce_source_o && rate_i inside {HBR_RATE_10M, HBR_RATE_100M} ##1 $stable(rate_i)
			|-> !out_ce_source_o;
	endproperty
	a_ce_gap: assert property (p_ce_gap) else $error("ce too long");
	property p_hold;
		!out_ce_sink_i |=> $stable(gmii_rxd_o);
	endproperty
	a_hold: assert property (p_hold) else $error("rx word moved");
	property p_take;
		!host_cs_n_i && $past(host_cs_n_i) && host_ready_n_o && $past(host_ready_n_o)
			|=> !host_ready_n_o;
	endproperty
	a_take: assert property (p_take) else $error("no ready");
	property p_stand;
		!host_ready_n_o && !host_cs_n_i |=> !host_ready_n_o;
	endproperty
	a_stand: assert property (p_stand) else $error("ready dropped");
	property p_end;
		!host_ready_n_o && host_cs_n_i |=> host_ready_n_o;
	endproperty
	a_end: assert property (p_end) else $error("ready stuck");
endmodule : hbr_props
`default_nettype wire

// ---- verification/hbr_host_model.sv ----
// Host bus master model for the management port.
`timescale 1ns/10ps
`default_nettype none
module hbr_host_model (
	input  wire logic       clk_i,
	input  wire logic       host_ready_n_i,
	input  wire logic [7:0] host_rdata_i,
	output logic            host_cs_n_o,
	output logic            host_write_n_o,
	output logic      [5:0] host_addr_o,
	output logic      [7:0] host_wdata_o
);
	// Counts handshakes whose answer never came within the wait limit.
	int n_timeouts = 0;
	initial begin
		host_cs_n_o = 1'b1;
		host_write_n_o = 1'b1;
		host_addr_o = 6'h00;
		host_wdata_o = 8'h00;
	end
	task automatic xfer(input logic wr, input logic [5:0] a, input logic [7:0] d,
		output logic [7:0] q);
		int n;
		n = 0;
		@(negedge clk_i);
		host_cs_n_o = 1'b0;
		host_write_n_o = !wr;
		host_addr_o = a;
		host_wdata_o = d;
		do @(negedge clk_i); while (host_ready_n_i !== 1'b0 && ++n < 20);
		if (host_ready_n_i !== 1'b0) n_timeouts++;
		q = host_rdata_i;
		@(negedge clk_i);
		host_cs_n_o = 1'b1;
		host_write_n_o = 1'b1;
		host_addr_o = ~a;
		host_wdata_o = ~d;
		do @(negedge clk_i); while (host_ready_n_i !== 1'b1 && ++n < 40);
		if (host_ready_n_i !== 1'b1) n_timeouts++;
	endtask : xfer
endmodule : hbr_host_model
`default_nettype wire

// ---- verification/testbench.sv ----
// Self-checking testbench for receive pacing and host bus.
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import hbr_pkg::*;
	logic            clk_i, sys_rst_i, sink_en, rx_valid;
	hbr_rate_t       rate;
	logic      [9:0] rx_word;
	wire logic       ce_src, rx_ready, cs_n, wr_n, rdy_n, dv, er;
	wire logic [7:0] rxd, rdata, wdata;
	wire logic [5:0] addr;
	int              n_errors = 0;
	int              total_checks = 0;
	hbr_top DUT (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .rate_i(rate), .out_ce_source_o(ce_src),
		.out_ce_sink_i(ce_src & sink_en), .rx_valid_i(rx_valid), .rx_ready_o(rx_ready),
		.rx_data_i(rx_word[7:0]), .rx_dv_i(rx_word[8]), .rx_er_i(rx_word[9]), .gmii_rxd_o(rxd),
		.gmii_rx_dv_o(dv), .gmii_rx_er_o(er), .host_cs_n_i(cs_n), .host_write_n_i(wr_n),
		.host_addr_i(addr), .host_wdata_i(wdata), .host_rdata_o(rdata), .host_ready_n_o(rdy_n));
	hbr_host_model host (.clk_i(clk_i), .host_ready_n_i(rdy_n), .host_rdata_i(rdata),
		.host_cs_n_o(cs_n), .host_write_n_o(wr_n), .host_addr_o(addr), .host_wdata_o(wdata));
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	task automatic check(input logic [9:0] got, input logic [9:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask : check
	task automatic finish_test();
		check(10'(host.n_timeouts), 10'h000);
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : finish_test
	task automatic t_regs();
		logic [7:0] q;
		host.xfer(1'b1, 6'h00, 8'h5a, q);
		host.xfer(1'b1, 6'h3f, 8'ha5, q);
		host.xfer(1'b0, 6'h00, 8'h00, q);
		check({2'h0, q}, 10'h05a);
		host.xfer(1'b0, 6'h3f, 8'h00, q);
		check({2'h0, q}, 10'h0a5);
		host.xfer(1'b0, 6'h15, 8'h00, q);
		check({2'h0, q}, 10'h000);
	endtask : t_regs
	task automatic t_ce();
		hbr_rate_t rt[4] = '{HBR_RATE_10M, HBR_RATE_100M, HBR_RATE_1G, hbr_rate_t'(2'b11)};
		int        want[4] = '{2, 20, 200, 200};
		int        c;
		foreach (rt[i]) begin
			rate = rt[i];
			repeat (20) @(negedge clk_i);
			c = 0;
			repeat (200) begin
				@(negedge clk_i);
				c += ce_src;
			end
			check(10'(c), 10'(want[i]));
		end
	endtask : t_ce
	task automatic push(input logic [9:0] w);
		@(negedge clk_i);
		rx_valid = 1'b1;
		rx_word = w;
		while (rx_ready !== 1'b1) @(negedge clk_i);
		@(negedge clk_i);
		rx_valid = 1'b0;
		rx_word = ~w;
	endtask : push
	task automatic t_rx();
		logic [9:0] exp[4] = '{10'h1a5, 10'h3c3, 10'h15a, 10'h000};
		logic [9:0] q[$];
		logic [9:0] last;
		rate = HBR_RATE_100M;
		sink_en = 1'b0;
		push(exp[0]);
		push(exp[1]);
		check({9'h0, rx_ready}, 10'h000);
		check({er, dv, rxd}, 10'h000);
		sink_en = 1'b1;
		last = 10'h000;
		fork
			push(exp[2]);
			repeat (80) begin
				@(negedge clk_i);
				if ({er, dv, rxd} !== last) begin
					last = {er, dv, rxd};
					q.push_back(last);
				end
			end
		join
		check(10'(q.size()), 10'h004);
		foreach (exp[i]) check(q[i], exp[i]);
	endtask : t_rx
	task automatic t_reset();
		logic [7:0] q;
		rate = HBR_RATE_1G;
		sink_en = 1'b0;
		push(10'h2e7);
		push(10'h11c);
		sink_en = 1'b1;
		@(negedge clk_i);
		sink_en = 1'b0;
		push(10'h0f0);
		check({er, dv, rxd}, 10'h2e7);
		host.xfer(1'b0, 6'h3f, 8'h00, q);
		check({2'h0, q}, 10'h0a5);
		sys_rst_i = 1'b1;
		repeat (10) @(negedge clk_i);
		check({7'h00, ce_src, rdy_n, rx_ready}, 10'h003);
		check({er, dv, rxd}, 10'h000);
		check({2'h0, rdata}, 10'h000);
		sys_rst_i = 1'b0;
		@(negedge clk_i);
		check({9'h000, ce_src}, 10'h001);
		// A buffer that survived reset would now launch its stale words.
		sink_en = 1'b1;
		repeat (3) @(negedge clk_i);
		check({er, dv, rxd}, 10'h000);
		host.xfer(1'b0, 6'h3f, 8'h00, q);
		check({2'h0, q}, 10'h000);
	endtask : t_reset
	initial begin
		sys_rst_i = 1'b1;
		rate = HBR_RATE_1G;
		sink_en = 1'b1;
		rx_valid = 1'b0;
		rx_word = 10'h000;
		repeat (10) @(negedge clk_i);
		sys_rst_i = 1'b0;
		t_regs();
		t_ce();
		t_rx();
		t_reset();
		finish_test();
	end
	initial begin
		#20000;
		n_errors++;
		finish_test();
	end
endmodule : testbench
bind hbr_top hbr_props u_props (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .rate_i(rate_i),
	.out_ce_source_o(out_ce_source_o), .out_ce_sink_i(out_ce_sink_i), .gmii_rxd_o(gmii_rxd_o),
	.host_cs_n_i(host_cs_n_i), .host_ready_n_o(host_ready_n_o));
`default_nettype wire
